/* File: ods_pkg.sv */
// constants for the octal driver serial command and status block
package ods_pkg;
	localparam int unsigned NUM_CH        = 8;     // driver channels
	localparam int unsigned NUM_PAIR      = 4;     // thermal channel pairs
	localparam int unsigned NUM_PAR       = 4;     // parallel control pins, ch5..ch8
	localparam int unsigned WORD_BITS     = 16;    // serial word length
	localparam int unsigned CNT_BITS      = 4;     // rising edge counter, modulo 16
	// command word fields
	localparam int unsigned CMD_ON_LSB    = 0;     // driver-on bits 0..7
	localparam int unsigned CMD_DIAG_LSB  = 8;     // open-load diagnostic bits 8..15
	// status word fields
	localparam int unsigned ST_TW_BIT     = 0;     // thermal warning
	localparam int unsigned ST_CH_LSB     = 1;     // channel fault bits 1..8
	localparam int unsigned ST_PAR_LSB    = 9;     // parallel pin bits 9..12
	localparam int unsigned ST_UNUSED_LSB = 13;    // unused bits 13..14
	localparam int unsigned ST_SUPPLY_BIT = 15;    // load supply fail
	localparam int unsigned PAR_FIRST_CH  = 4;     // zero-based index of channel 5
	// reset values
	localparam logic [15:0] CMD_RESET     = 16'h0000;
	localparam logic [15:0] SHIFT_RESET   = 16'h0000;
	localparam logic [3:0]  CNT_RESET     = 4'h0;
	// pin synchronisers: only the chip select stage (bit 27) idles high
	localparam logic [29:0] SYNC_RESET    = 30'h0800_0000;
endpackage

/* File: ods_spi_core.sv */
// serial command and status logic of an eight channel power driver
`timescale 1ns/1ps
`default_nettype none
module ods_spi_core
	import ods_pkg::*;
(
	input  wire logic              i_clk,                 // system clock, 100 MHz
	input  wire logic              i_rst,                 // async reset, active high
	input  wire logic              i_enable,              // enable pin, low clears command and fault latches
	input  wire logic              i_sclk,                // serial clock pin
	input  wire logic              i_chip_select_n,       // chip select pin, active low
	input  wire logic              i_sdi,                 // serial data in pin
	input  wire logic              i_parallel_control_ch5, // parallel control ch5
	input  wire logic              i_parallel_control_ch6, // parallel control ch6
	input  wire logic              i_parallel_control_ch7, // parallel control ch7
	input  wire logic              i_parallel_control_ch8, // parallel control ch8
	input  wire logic [NUM_CH-1:0] i_open_load,           // open load detector per channel
	input  wire logic [NUM_CH-1:0] i_over_current,        // overcurrent detector per channel
	input  wire logic [NUM_PAIR-1:0] i_over_temp,         // shutdown detector per pair
	input  wire logic              i_thermal_warning_flag, // thermal warning detector
	input  wire logic              i_load_supply_fail,    // load supply out of range
	output logic [NUM_CH-1:0]      o_driver_on,           // effective output stage on
	output logic [NUM_CH-1:0]      o_open_load_diag_en,   // open-load detection enable
	output logic                   o_sdo,                 // serial data out
	output logic                   o_sdo_oe               // serial out enable, high drives
);
	localparam int unsigned SYNC_W = 30;

	// two-flop synchronisers for every outside input
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [SYNC_W-1:0] async_in;
	assign async_in = {i_enable, i_sclk, i_chip_select_n, i_sdi,
		i_parallel_control_ch8, i_parallel_control_ch7,
		i_parallel_control_ch6, i_parallel_control_ch5,
		i_open_load, i_over_current, i_over_temp,
		i_thermal_warning_flag, i_load_supply_fail};
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1 <= SYNC_RESET; // deselected, so no false select edge
			sync2 <= SYNC_RESET;
		end
		else
		begin
			sync1 <= async_in;
			sync2 <= sync1;
		end
	end

	// synchronised views
	logic                s_en;
	logic                s_sclk;
	logic                s_csn;
	logic                s_sdi;
	logic [NUM_PAR-1:0]  s_par;
	logic [NUM_CH-1:0]   s_ol;
	logic [NUM_CH-1:0]   s_oc;
	logic [NUM_PAIR-1:0] s_ot;
	logic                s_tw;
	logic                s_sfail;
	assign {s_en, s_sclk, s_csn, s_sdi, s_par, s_ol, s_oc, s_ot, s_tw, s_sfail} = sync2;

	// link state registers
	logic                sclk_d;
	logic                csn_d;
	logic [WORD_BITS-1:0] shreg;
	logic                in_bit;
	logic [CNT_BITS-1:0] cnt;
	logic                seen;
	logic                pend;                  // bit taken on a rise, not yet shifted
	logic [WORD_BITS-1:0] cmd;
	logic [WORD_BITS-1:0] next_shreg;
	logic                next_in_bit;
	logic [CNT_BITS-1:0] next_cnt;
	logic                next_seen;
	logic                next_pend;
	logic [WORD_BITS-1:0] next_cmd;
	logic                sclk_rise;
	logic                sclk_fall;
	logic                cs_fall;
	logic                cs_rise;
	logic                frame_ok;
	logic [WORD_BITS-1:0] word_in;
	logic [WORD_BITS-1:0] status;

	// edge detection on the sampled link
	assign sclk_rise = s_sclk & ~sclk_d & ~s_csn;
	assign sclk_fall = ~s_sclk & sclk_d & ~s_csn;
	assign cs_fall   = csn_d & ~s_csn;
	assign cs_rise   = ~csn_d & s_csn;
	// a rise not yet followed by its fall still holds the last bit aside
	assign word_in   = pend ? {in_bit, shreg[WORD_BITS-1:1]} : shreg;
	assign frame_ok  = cs_rise & seen & (cnt == CNT_RESET);

	// shifter, edge counter and command register
	always_comb
	begin
		next_shreg  = shreg;
		next_in_bit = in_bit;
		next_cnt    = cnt;
		next_seen   = seen;
		next_pend   = pend;
		next_cmd    = cmd;
		if (cs_fall)
		begin
			next_shreg = status;
			next_cnt   = CNT_RESET;
			next_seen  = 1'b0;
			next_pend  = 1'b0;
		end
		else if (sclk_rise)
		begin
			next_in_bit = s_sdi;
			next_cnt    = CNT_BITS'(cnt + 1'b1);
			next_seen   = 1'b1;
			next_pend   = 1'b1;
		end
		else if (sclk_fall)
		begin
			next_shreg = {in_bit, shreg[WORD_BITS-1:1]};
			next_pend  = 1'b0;
		end
		if (frame_ok)
			next_cmd = word_in;
		if (!s_en)
			next_cmd = CMD_RESET;
	end
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sclk_d <= 1'b0;
			csn_d  <= 1'b1;
			shreg  <= SHIFT_RESET;
			in_bit <= 1'b0;
			cnt    <= CNT_RESET;
			seen   <= 1'b0;
			pend   <= 1'b0;
			cmd    <= CMD_RESET;
		end
		else
		begin
			sclk_d <= s_sclk;
			csn_d  <= s_csn;
			shreg  <= next_shreg;
			in_bit <= next_in_bit;
			cnt    <= next_cnt;
			seen   <= next_seen;
			pend   <= next_pend;
			cmd    <= next_cmd;
		end
	end

	// serial output from the shifter, driven only while selected
	assign o_sdo    = shreg[0];
	assign o_sdo_oe = ~s_csn;

	// fault latches and channel control
	logic [NUM_CH-1:0]   oc_lat;
	logic [NUM_PAIR-1:0] ts_lat;
	logic                sup_lat;
	logic                freeze;
	logic [NUM_PAR-1:0]  par_cap;
	logic [NUM_CH-1:0]   next_oc_lat;
	logic [NUM_PAIR-1:0] next_ts_lat;
	logic                next_sup_lat;
	logic                next_freeze;
	logic [NUM_PAR-1:0]  next_par_cap;
	logic [NUM_CH-1:0]   want_on;
	logic [NUM_CH-1:0]   ch_fault;
	logic                fault_new;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			// parallel pin ORed in for channels 5..8
			if (g >= PAR_FIRST_CH)
			begin : g_par
				assign want_on[g] = cmd[CMD_ON_LSB+g] | s_par[g-PAR_FIRST_CH];
			end
			else
			begin : g_spi
				assign want_on[g] = cmd[CMD_ON_LSB+g];
			end
			// overcurrent latch, set wins over the frame clear
			assign next_oc_lat[g] = s_en & ((s_oc[g] & want_on[g]) | (oc_lat[g]
				& ~(frame_ok & ~word_in[CMD_ON_LSB+g])));
			assign o_driver_on[g] = want_on[g] & ~oc_lat[g] & ~ts_lat[g/2]
				& ~s_sfail & s_en;
			assign o_open_load_diag_en[g] = cmd[CMD_DIAG_LSB+g];
			// any of three causes raises the channel bit
			assign ch_fault[g] = oc_lat[g] | ts_lat[g/2]
				| (~want_on[g] & cmd[CMD_DIAG_LSB+g] & s_ol[g]);
		end
		for (g = 0; g < NUM_PAIR; g++)
		begin : g_pair
			// shutdown latch clears when cool and both pair channels off
			assign next_ts_lat[g] = s_en & (s_ot[g] | (ts_lat[g] & ~(frame_ok
				& ~word_in[CMD_ON_LSB+2*g] & ~word_in[CMD_ON_LSB+2*g+1])));
		end
	endgenerate

	// supply latch and parallel pin capture
	always_comb
	begin
		fault_new    = |(next_oc_lat & ~oc_lat) | |(next_ts_lat & ~ts_lat);
		next_sup_lat = s_en & (s_sfail | (sup_lat & ~frame_ok));
		next_freeze  = s_en & (fault_new | (freeze & ((|oc_lat) | (|ts_lat))));
		next_par_cap = (fault_new | ~freeze) ? s_par : par_cap;
	end
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			oc_lat  <= '0;
			ts_lat  <= '0;
			sup_lat <= 1'b0;
			freeze  <= 1'b0;
			par_cap <= '0;
		end
		else
		begin
			oc_lat  <= next_oc_lat;
			ts_lat  <= next_ts_lat;
			sup_lat <= next_sup_lat;
			freeze  <= next_freeze;
			par_cap <= next_par_cap;
		end
	end

	// status word assembled for the next frame
	always_comb
	begin
		status = '0;
		status[ST_TW_BIT] = s_tw;
		status[ST_CH_LSB +: NUM_CH] = ch_fault;
		status[ST_PAR_LSB +: NUM_PAR] = freeze ? par_cap : s_par;
		status[ST_SUPPLY_BIT] = sup_lat;
	end

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence frame_end_s;
		frame_ok;
	endsequence
	sequence select_s;
		cs_fall;
	endsequence

	sdo_tristate_a: assert property (s_csn |-> !o_sdo_oe)
		else $error("serial out driven while deselected");
	warn_first_a: assert property (select_s |=> o_sdo == $past(s_tw))
		else $error("warning bit not first on serial out");
	frame_commit_a: assert property (frame_end_s ##0 s_en |=> cmd == $past(word_in))
		else $error("valid frame not committed");
	bad_frame_a: assert property (cs_rise && !frame_ok && s_en |=> $stable(cmd))
		else $error("invalid frame changed command");
	diag_enable_a: assert property (frame_end_s ##0 s_en
		|=> o_open_load_diag_en == $past(word_in[15:8]))
		else $error("diagnostic enables wrong after frame");
	oc_hold_a: assert property (oc_lat[0] && s_en && !(frame_ok && !word_in[0])
		|=> oc_lat[0])
		else $error("overcurrent latch dropped early");
	oc_off_a: assert property ((oc_lat & o_driver_on) == '0)
		else $error("latched channel still driven");
	ts_hold_a: assert property (s_ot[0] && s_en |=> ts_lat[0])
		else $error("shutdown latch cleared while hot");
	supply_set_a: assert property ($rose(s_sfail) && s_en |=> status[15])
		else $error("supply fail not latched");
	unused_zero_a: assert property (status[14:13] == 2'h0)
		else $error("unused status bits set");
	par_or_a: assert property (s_par[0] && !oc_lat[4] && !ts_lat[2] && !s_sfail && s_en
		|-> o_driver_on[4])
		else $error("parallel pin did not turn channel on");
	open_load_a: assert property (!want_on[0] && cmd[8] && s_ol[0] |-> status[1])
		else $error("open load not reported");
	par_mirror_a: assert property (!freeze |-> status[12:9] == s_par)
		else $error("parallel pins not mirrored");
	par_hold_a: assert property (freeze && !fault_new |=> !freeze || $stable(par_cap))
		else $error("captured pins changed during fault");
endmodule
`default_nettype wire

/* File: ods_spi_master.sv */
// behavioural serial master for the link pins of the block
`timescale 1ns/1ps
`default_nettype none
module ods_spi_master
(
	input  wire logic i_clk,  // bench clock, pins move on its fall
	input  wire logic i_sdo,  // serial data from the block
	output var logic  o_sclk, // serial clock, low between frames
	output var logic  o_csn,  // chip select, active low
	output var logic  o_sdi   // serial data, pulled low when idle
);
	// idle levels of the pins
	initial
	begin
		o_sclk = 1'b0;
		o_csn = 1'b1;
		o_sdi = 1'b0;
	end
	// wait for falling edges of the bench clock
	task automatic w(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// one frame of n clocks, lsb first, keeps the last 16 bits read
	task automatic xfer(input logic [31:0] c, input int n, output logic [15:0] r);
		int i;
		r = 16'h0000;
		w(1);
		o_csn = 1'b0;
		for (i = 0; i < n; i++)
		begin
			o_sdi = c[i];
			w(7);
			o_sclk = 1'b1;
			r = {i_sdo, r[15:1]};
			w(6);
			o_sclk = 1'b0;
		end
		w(7);
		o_csn = 1'b1;
		o_sdi = 1'b0;
		w(8);
	endtask
endmodule
`default_nettype wire

/* File: tb_ods_spi_core.sv */
// self-checking bench for the octal driver serial block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_ods_spi_core
	import ods_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              en = 1'b1;
	logic              tw = 1'b0;
	logic              sf = 1'b0;
	logic [3:0]        pin = 4'h0;
	logic [3:0]        ot = 4'h0;
	logic [NUM_CH-1:0] ol = 8'h00;
	logic [NUM_CH-1:0] oc = 8'h00;
	logic [15:0]       st;
	wire logic         sclk;
	wire logic         csn;
	wire logic         sdi;
	wire logic         sdo;
	wire logic         oe;
	wire logic [7:0]   drv;
	wire logic [7:0]   diag;
	int                mismatches = 0;
	int                num_checks = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	// block and its serial master
	ods_spi_core u_ods_spi_core (.i_clk(clk), .i_rst(rst), .i_enable(en), .i_sclk(sclk),
		.i_chip_select_n(csn), .i_sdi(sdi), .i_parallel_control_ch5(pin[0]),
		.i_parallel_control_ch6(pin[1]), .i_parallel_control_ch7(pin[2]),
		.i_parallel_control_ch8(pin[3]), .i_open_load(ol), .i_over_current(oc),
		.i_over_temp(ot), .i_thermal_warning_flag(tw), .i_load_supply_fail(sf),
		.o_driver_on(drv), .o_open_load_diag_en(diag), .o_sdo(sdo), .o_sdo_oe(oe));
	ods_spi_master u_ods_spi_master (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_csn(csn),
		.o_sdi(sdi));
	// frame helper and edge wait
	task automatic fr(input logic [31:0] c, input int n);
		u_ods_spi_master.xfer(c, n, st);
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	// verdict
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#500000;
		mismatches++;
		finish_test();
	end
	// test sequence
	initial
	begin
		w(4);
		rst = 1'b0;
		w(3);
		fr(32'hA53C, 16);
		`CHK(drv, 8'h3C)
		`CHK(diag, 8'hA5)
		fr(32'h00FF, 15);
		`CHK(drv, 8'h3C)
		fr(32'h0081_1111, 32);
		`CHK(st, 16'h1111)
		`CHK(drv, 8'h81)
		$display("test frames done");
		pin = 4'h5;
		w(4);
		`CHK(drv, 8'hD1)
		fr(32'h0000, 16);
		`CHK(st, 16'h0A00)
		pin = 4'h0;
		tw = 1'b1;
		fr(32'h0000, 16);
		`CHK(st, 16'h0001)
		u_ods_spi_master.o_csn = 1'b0;
		w(6);
		`CHK(sdo, 1'b1)
		`CHK(oe, 1'b1)
		u_ods_spi_master.o_csn = 1'b1;
		w(6);
		`CHK(oe, 1'b0)
		tw = 1'b0;
		$display("test pins and warning done");
		fr(32'h0001, 16);
		pin = 4'h2;
		oc = 8'h01;
		w(5);
		oc = 8'h00;
		pin = 4'h0;
		w(5);
		`CHK(drv, 8'h00)
		fr(32'h0001, 16);
		`CHK(st, 16'h0402)
		fr(32'h0000, 16);
		`CHK(st, 16'h0402)
		fr(32'h0200, 16);
		`CHK(st, 16'h0000)
		ol = 8'h02;
		w(4);
		fr(32'h0200, 16);
		`CHK(st, 16'h0004)
		ol = 8'h00;
		fr(32'h0003, 16);
		`CHK(st, 16'h0000)
		$display("test overcurrent and open load done");
		ot = 4'h1;
		w(5);
		`CHK(drv, 8'h00)
		fr(32'h0000, 16);
		`CHK(st, 16'h0006)
		ot = 4'h0;
		fr(32'h0010, 16);
		`CHK(st, 16'h0006)
		fr(32'h0010, 16);
		`CHK(st, 16'h0000)
		sf = 1'b1;
		w(5);
		`CHK(drv, 8'h00)
		sf = 1'b0;
		w(5);
		fr(32'h0010, 16);
		`CHK(st, 16'h8000)
		fr(32'hFF10, 16);
		`CHK(st, 16'h0000)
		`CHK(diag, 8'hFF)
		en = 1'b0;
		w(5);
		`CHK(diag, 8'h00)
		`CHK(drv, 8'h00)
		en = 1'b1;
		w(4);
		`CHK(drv, 8'h00)
		$display("test latches done");
		finish_test();
	end
endmodule
`default_nettype wire
